// file: hbc_ctrl.sv
// Host bus control signal generator: read cycle sequencing and pins.
// Assumes the destination decoder and setup port run on mclk_i.
// What this block does
// - After reset host port is off, inputs ignored, outputs undriven.
// - Setting lock bit at 1Fh enables access and freezes host config.
// - Each host input and output has its own active polarity.
// - Host outputs are open drain or push pull by configuration.
// - Read pin is a read strobe or a direction level.
// - Write pin is a write strobe or a transfer strobe.
// - Wait mode stretches the host cycle; ack mode marks its end.
// - Card enable chosen by access type and slot.
// - REG# only for attribute, I/O and extended channel cycles.
// - OE# for memory reads, IORD# for I/O, channel and external.
// - Length counter freezes while the target slot holds wait.
// - Attribute allows 600/300 only; common has no 300 timing.
// - I/O, channel and external reads share one timing profile.
// - Read strobe and buffer direction follow enable by 3, 1 or 2.
// - Base read length 14,8,7,5,4,3 clocks; I/O profile 3.
// - At length expiry wait ends or ack rises, address latch drops.
// - Read strobe holds 0 or 2 clocks past length expiry.
// - Host end releases strobe, isolates data, then flips direction.
// - One clock after strobe release, enable, REG# and latch free.
// - Data buffers stay off 5, 3 or 2 clocks after strobe release.
// - Start detection takes a synchroniser plus one decode clock.
`default_nettype none
module hbc_ctrl
   import hbc_pkg::*;
(
   input wire logic mclk_i,              // Core clock
   input wire logic reset_n_i,           // Sync reset, active low
   input wire logic cfg_we_i,            // Setup port write strobe
   input wire logic [7:0] cfg_addr_i,    // Setup port address
   input wire logic [7:0] cfg_wdata_i,   // Setup port write data
   output logic [7:0] cfg_rdata_o,       // Setup port read data
   input wire hbc_cfg_t host_cfg_i,      // Host pin configuration
   input wire hbc_acc_t acc_i,           // Decoded access description
   input wire logic irq_req_i,           // Interrupt request, internal
   input wire logic host_cs_i,           // Host chip select pin
   input wire logic host_read_or_dir_i,  // Host read or direction pin
   input wire logic host_write_or_strobe_i, // Host write or strobe pin
   input wire logic slot_a_wait_n_i,     // Slot A wait pin
   input wire logic slot_b_wait_n_i,     // Slot B wait pin
   output logic host_wait_or_ack_o,      // Wait/ack level
   output logic host_wait_or_ack_oe_o,   // Wait/ack drive enable
   output logic host_irq_o,              // Interrupt level
   output logic host_irq_oe_o,           // Interrupt drive enable
   output logic slot_a_primary_enable_n_o,   // Slot A enable 1
   output logic slot_a_secondary_enable_n_o, // Slot A enable 2
   output logic slot_b_primary_enable_n_o,   // Slot B enable 1
   output logic slot_b_secondary_enable_n_o, // Slot B enable 2
   output logic aux_peripheral_select_n_o,   // Aux select, regenerate
   output logic reg_n_o,                 // Attribute/IO space select
   output logic oe_n_o,                  // Memory read strobe
   output logic we_n_o,                  // Memory write strobe
   output logic iord_n_o,                // I/O read strobe
   output logic iowr_n_o,                // I/O write strobe
   output logic addr_buffer_latch_en_o,  // Address latch enable
   output logic addr_buffer_oe_n_o,      // Address buffer enable
   output logic data_buffer_dir_o,       // 1: card to host
   output logic data_buffer_oe_n_o       // Data buffer enable
);
   // -------------------------------------------------------------
   // Declarations and helpers
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_SETUP, ST_LEN, ST_HOLD,
      ST_ISO, ST_REL, ST_REC
   } hbc_state_t;

   logic lock_reg;
   hbc_cfg_t cfg_reg;
   hbc_acc_t acc_reg;
   hbc_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [2:0] pin_s1_reg;
   logic [2:0] pin_s2_reg;
   logic [1:0] wait_s1_reg;
   logic [1:0] wait_s2_reg;
   logic cs_act, rd_pin_act, wr_pin_act, dir_read, rd_act;
   logic tgt_wait, ce_on, strobe_on, mem_read;
   logic wa_act;
   hbc_tim_t tim_eff;

   // Pin level to active flag under a configured polarity
   function automatic logic pin_act(input logic pin, input logic pol);
      pin_act = ~(pin ^ pol);
   endfunction

   // Effective timing: spaces narrow the choice of speeds
   function automatic hbc_tim_t eff_tim(input hbc_acc_t a);
      eff_tim = a.tim;
      if (a.space == SP_IO || a.space == SP_EC || a.space == SP_EXT) begin
         eff_tim = TM_IO;
      end else if (a.space == SP_ATTR) begin
         if (a.tim != TM_600) begin
            eff_tim = TM_300;
         end
      end else if (a.tim == TM_300 || a.tim == TM_IO) begin
         eff_tim = TM_250;
      end
   endfunction

   // -------------------------------------------------------------
   // Control register and configuration freeze
   // -------------------------------------------------------------
   // Lock is sticky until reset so the host config cannot shift mid-run
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         lock_reg <= CTRL_RESET[LOCK_BIT];
      end else if (cfg_we_i && cfg_addr_i == CTRL_ADDR &&
                   cfg_wdata_i[LOCK_BIT]) begin
         lock_reg <= 1'b1;
      end
   end

   // Host configuration follows the input only while unlocked
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         cfg_reg <= CFG_RESET;
      end else if (!lock_reg) begin
         cfg_reg <= host_cfg_i;
      end
   end

   // Read back: lock and a busy flag showing a cycle in flight
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         cfg_rdata_o <= CTRL_RESET;
      end else if (cfg_addr_i == CTRL_ADDR) begin
         cfg_rdata_o <= CTRL_RESET;
         cfg_rdata_o[LOCK_BIT] <= lock_reg;
         cfg_rdata_o[BUSY_BIT] <= (state_reg != ST_IDLE);
      end else begin
         cfg_rdata_o <= CTRL_RESET;
      end
   end

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   // Two stages on every asynchronous pin before any decode
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         wait_s1_reg <= '1;
         wait_s2_reg <= '1;
      end else begin
         pin_s1_reg <= {host_cs_i, host_read_or_dir_i,
                        host_write_or_strobe_i};
         pin_s2_reg <= pin_s1_reg;
         wait_s1_reg <= {slot_b_wait_n_i, slot_a_wait_n_i};
         wait_s2_reg <= wait_s1_reg;
      end
   end

   // -------------------------------------------------------------
   // Host cycle decode
   // -------------------------------------------------------------
   // Inputs count only after lock; write cycles are not served here
   assign cs_act = pin_act(pin_s2_reg[2], cfg_reg.cs_pol);
   assign rd_pin_act = pin_act(pin_s2_reg[1], cfg_reg.rd_pol);
   assign wr_pin_act = pin_act(pin_s2_reg[0], cfg_reg.wr_pol);
   assign dir_read = rd_pin_act; // Active direction level means read
   assign rd_act = lock_reg && cs_act &&
      (cfg_reg.write_pin_func_sel ? (wr_pin_act && dir_read)
                    : (!cfg_reg.read_pin_func_sel && rd_pin_act));

   // Only the target slot may stretch; aux has no wait input
   always_comb begin
      tgt_wait = 1'b0;
      if (acc_reg.dest == DST_A) begin
         tgt_wait = !wait_s2_reg[0];
      end else if (acc_reg.dest == DST_B) begin
         tgt_wait = !wait_s2_reg[1];
      end
   end

   assign tim_eff = eff_tim(acc_reg);

   // -------------------------------------------------------------
   // Read sequencer
   // -------------------------------------------------------------
   // State walk: start, enable, strobe, hold, isolate, release, recover
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= CNT_ZERO;
         acc_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (rd_act) begin
                  state_reg <= ST_START;
                  acc_reg <= acc_i;
               end
            end
            ST_START: begin
               state_reg <= ST_SETUP;
               cnt_reg <= T3_CYC[eff_tim(acc_reg)];
            end
            ST_SETUP: begin
               if (cnt_reg <= CNT_ONE) begin
                  state_reg <= ST_LEN;
                  cnt_reg <= T4_CYC[tim_eff];
               end else begin
                  cnt_reg <= cnt_reg - CNT_ONE;
               end
            end
            ST_LEN: begin
               if (tgt_wait) begin
                  cnt_reg <= cnt_reg;
               end else if (cnt_reg <= CNT_ONE) begin
                  state_reg <= ST_HOLD;
                  cnt_reg <= T5_CYC[tim_eff];
               end else begin
                  cnt_reg <= cnt_reg - CNT_ONE;
               end
            end
            ST_HOLD: begin
               if (cnt_reg != CNT_ZERO) begin
                  cnt_reg <= cnt_reg - CNT_ONE;
               end else if (!rd_act) begin
                  state_reg <= ST_ISO;
               end
            end
            ST_ISO: begin
               state_reg <= ST_REL;
               cnt_reg <= T10_CYC[tim_eff] - CNT_TWO;
            end
            ST_REL: begin
               state_reg <= ST_REC;
            end
            ST_REC: begin
               if (cnt_reg == CNT_ZERO) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - CNT_ONE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Card side strobes and buffers
   // -------------------------------------------------------------
   assign ce_on = (state_reg == ST_SETUP) || (state_reg == ST_LEN) ||
                  (state_reg == ST_HOLD) || (state_reg == ST_ISO);
   assign strobe_on = (state_reg == ST_LEN) || (state_reg == ST_HOLD);
   assign mem_read = (acc_reg.space == SP_ATTR) ||
                     (acc_reg.space == SP_COMMON);

   // Enable per destination and space
   assign slot_a_primary_enable_n_o = !(ce_on && acc_reg.dest == DST_A &&
      acc_reg.space != SP_EC && acc_reg.space != SP_EXT);
   assign slot_b_primary_enable_n_o = !(ce_on && acc_reg.dest == DST_B &&
      acc_reg.space != SP_EC && acc_reg.space != SP_EXT);
   assign slot_a_secondary_enable_n_o = !(ce_on &&
      acc_reg.dest == DST_A && acc_reg.space == SP_EC);
   assign slot_b_secondary_enable_n_o = !(ce_on &&
      acc_reg.dest == DST_B && acc_reg.space == SP_EC);
   assign aux_peripheral_select_n_o = !(ce_on &&
      acc_reg.space == SP_EXT);
   assign reg_n_o = !(ce_on && acc_reg.space != SP_COMMON &&
      acc_reg.space != SP_EXT);
   assign oe_n_o = !(strobe_on && mem_read);
   assign iord_n_o = !(strobe_on && !mem_read);
   // Write cycles are handled elsewhere; these strobes stay idle
   assign we_n_o = 1'b1;
   assign iowr_n_o = 1'b1;

   // Latch held from length expiry until one clock past strobe release
   assign addr_buffer_latch_en_o = !((state_reg == ST_HOLD) ||
      (state_reg == ST_ISO));
   assign addr_buffer_oe_n_o = !lock_reg;
   // Direction flips with the strobe and returns after isolation
   assign data_buffer_dir_o = strobe_on || (state_reg == ST_ISO);
   assign data_buffer_oe_n_o = !lock_reg || (state_reg == ST_ISO) ||
      (state_reg == ST_REL) || (state_reg == ST_REC);

   // -------------------------------------------------------------
   // Host side outputs
   // -------------------------------------------------------------
   // Wait spans detection to expiry; ack spans expiry to host end
   assign wa_act = cfg_reg.ack_mode ? (state_reg == ST_HOLD)
      : ((state_reg == ST_START) || (state_reg == ST_SETUP) ||
         (state_reg == ST_LEN));
   // Open drain drives only the active level; push pull drives whenever locked
   assign host_wait_or_ack_o = wa_act ? cfg_reg.wa_pol : !cfg_reg.wa_pol;
   assign host_wait_or_ack_oe_o = lock_reg &&
      (!cfg_reg.wa_od || wa_act);
   assign host_irq_o = irq_req_i ? cfg_reg.irq_pol : !cfg_reg.irq_pol;
   assign host_irq_oe_o = lock_reg &&
      (!cfg_reg.irq_od || irq_req_i);

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   localparam int DIR_MAX = DIR_BACK_CYC;
   logic [3:0] len_seen_reg;
   logic [3:0] setup_seen_reg;

   // Cycle counts of the enable-to-strobe and unstretched length phases
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i || state_reg == ST_START) begin
         len_seen_reg <= CNT_ZERO;
         setup_seen_reg <= CNT_ZERO;
      end else if (state_reg == ST_SETUP) begin
         setup_seen_reg <= setup_seen_reg + CNT_ONE;
      end else if (state_reg == ST_LEN && !tgt_wait) begin
         len_seen_reg <= len_seen_reg + CNT_ONE;
      end
   end

   sequence seq_strobe_drop;
      $fell(strobe_on);
   endsequence
   sequence seq_release;
      ce_on ##1 !ce_on && addr_buffer_latch_en_o;
   endsequence

   chk_port_locked: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      !lock_reg |-> !host_wait_or_ack_oe_o && !host_irq_oe_o &&
      state_reg == ST_IDLE)
      else $error("host port active before lock");
   chk_setup_len: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      $rose(strobe_on) |-> setup_seen_reg == T3_CYC[tim_eff])
      else $error("enable to strobe delay wrong");
   chk_base_len: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      $rose(state_reg == ST_HOLD) |-> len_seen_reg == T4_CYC[tim_eff])
      else $error("read length wrong");
   chk_wait_freeze: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      state_reg == ST_LEN && tgt_wait |=> state_reg == ST_LEN &&
      $stable(cnt_reg))
      else $error("length counter ran during wait");
   chk_expiry_latch: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      $rose(state_reg == ST_HOLD) |-> !addr_buffer_latch_en_o &&
      (cfg_reg.ack_mode == wa_act))
      else $error("expiry did not latch or signal host");
   chk_ce_release: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      seq_strobe_drop |-> seq_release)
      else $error("enable not freed one clock after strobe");
   chk_reg_space: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      !reg_n_o |-> acc_reg.space != SP_COMMON &&
      acc_reg.space != SP_EXT)
      else $error("reg asserted for common or external");
   chk_read_strobe: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      !oe_n_o |-> mem_read && iord_n_o)
      else $error("wrong read strobe for space");
   chk_recover_gap: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      seq_strobe_drop |-> data_buffer_oe_n_o[*2])
      else $error("data buffers re-enabled too soon");
   chk_dir_back: assert property (@(posedge mclk_i)
      disable iff (!reset_n_i)
      seq_strobe_drop |-> data_buffer_oe_n_o ##[1:DIR_MAX]
      !data_buffer_dir_o)
      else $error("direction not restored after isolation");
endmodule
`default_nettype wire

// file: hbc_pkg.sv
// Shared constants and types for the host bus control signal generator.
// Assumes one 100 MHz core clock; counts are in core clock cycles.
`default_nettype none
package hbc_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h1f;
   localparam int LOCK_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // -------------------------------------------------------------
   // Access description and host pin configuration
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      SP_ATTR, SP_COMMON, SP_IO, SP_EC, SP_EXT
   } hbc_space_t;
   typedef enum logic [1:0] {DST_A, DST_B, DST_AUX} hbc_dest_t;
   typedef enum logic [2:0] {
      TM_600, TM_300, TM_250, TM_200, TM_150, TM_100, TM_IO
   } hbc_tim_t;
   typedef struct packed {
      hbc_dest_t dest;
      hbc_space_t space;
      hbc_tim_t tim;
   } hbc_acc_t;
   typedef struct packed {
      logic cs_pol;    // 1: active high
      logic rd_pol;
      logic wr_pol;
      logic wa_pol;
      logic irq_pol;
      logic wa_od;     // 1: open drain
      logic irq_od;
      logic read_pin_func_sel;      // 1: pin is a direction level
      logic write_pin_func_sel;      // 1: pin is a transfer strobe
      logic ack_mode;  // 1: acknowledge, 0: wait
   } hbc_cfg_t;
   localparam hbc_cfg_t CFG_RESET = '0;

   // -------------------------------------------------------------
   // Read timing tables, indexed by hbc_tim_t
   // -------------------------------------------------------------
   localparam logic [3:0] T3_CYC [7] = '{
      4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2};
   localparam logic [3:0] T4_CYC [7] = '{
      4'he, 4'h8, 4'h7, 4'h5, 4'h4, 4'h3, 4'h3};
   localparam logic [3:0] T5_CYC [7] = '{
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
   localparam logic [3:0] T10_CYC [7] = '{
      4'h5, 4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2};
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_TWO = 4'h2;
   localparam int CLK_NS = 10;
   localparam int DIR_BACK_NS = 70;
   localparam int DIR_BACK_CYC = DIR_BACK_NS / CLK_NS;
endpackage
`default_nettype wire

// file: hbc_card_model.sv
// Card slot model: answers module read strobes with an optional stretch.
// Assumes the bench sets the stretch length and slot before each access.
`default_nettype none
module hbc_card_model (
   input wire logic mclk_i,           // Core clock
   input wire logic strobe_n_i,       // Combined OE# and IORD#, active low
   input wire logic wait_b_i,         // 1: stretch on slot B, 0: slot A
   input wire logic [3:0] wait_len_i, // Stretch in cycles, 0 for none
   output logic slot_a_wait_n_o,      // Slot A wait, pulled up when idle
   output logic slot_b_wait_n_o       // Slot B wait, pulled up when idle
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_n = 1'b1;
   logic [3:0] left = 4'h0;
   // -------------------------------------------------------------
   // Stretch counter, started on the strobe's falling edge
   // -------------------------------------------------------------
   always @(posedge mclk_i) begin
      prev_n <= strobe_n_i;
      if (prev_n && !strobe_n_i)
         left <= wait_len_i;
      else if (left != 4'h0)
         left <= left - 4'h1;
   end
   // Wait pins sit at their pull-up level whenever no stretch runs
   assign slot_a_wait_n_o = !(left != 4'h0 && !wait_b_i);
   assign slot_b_wait_n_o = !(left != 4'h0 && wait_b_i);
endmodule
`default_nettype wire

// file: hbc_ctrl_tb_top.sv
// Self-checking bench for the host bus control signal generator.
// Assumes the package, the design and the card model are compiled first.
`default_nettype none
module hbc_ctrl_tb_top;
   import hbc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------------------------------------
   // Signals and expected timing tables, by effective timing
   // -------------------------------------------------------------
   logic mclk_i = 1'b0, reset_n_i = 1'b0, cfg_we_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o;
   hbc_cfg_t host_cfg_i = CFG_RESET, lk = CFG_RESET;
   hbc_acc_t acc_i = '0;
   logic irq_req_i = 1'b0, host_cs_i = 1'b0, host_read_or_dir_i = 1'b0;
   logic host_write_or_strobe_i = 1'b0, slot_a_wait_n_i, slot_b_wait_n_i;
   logic host_wait_or_ack_o, host_wait_or_ack_oe_o, host_irq_o;
   logic host_irq_oe_o, slot_a_primary_enable_n_o, reg_n_o, oe_n_o;
   logic slot_a_secondary_enable_n_o, slot_b_primary_enable_n_o;
   logic slot_b_secondary_enable_n_o, aux_peripheral_select_n_o, we_n_o;
   logic iord_n_o, iowr_n_o, addr_buffer_latch_en_o, addr_buffer_oe_n_o;
   logic data_buffer_dir_o, data_buffer_oe_n_o, wait_b = 1'b0;
   logic [3:0] wait_len = 4'h0;
   logic [4:0] en_vec;
   logic [1:0] st_vec;
   logic [7:0] v;
   int n_fail = 0, checked = 0, cyc = 0;
   logic [7:0] t3e [7] = '{8'h03, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
   logic [7:0] t4e [7] = '{8'h0e, 8'h08, 8'h07, 8'h05, 8'h04, 8'h03, 8'h03};
   logic [7:0] t5e [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
   logic [7:0] t10e [7] = '{8'h05, 8'h03, 8'h03, 8'h03, 8'h03, 8'h02, 8'h02};
   // Fields from cs_pol down to ack_mode; P2 also tries open drain wait
   localparam hbc_cfg_t P1 = hbc_cfg_t'(10'h3e1);
   localparam hbc_cfg_t P2 = hbc_cfg_t'(10'h09e);
   assign en_vec = {slot_a_primary_enable_n_o, slot_a_secondary_enable_n_o,
      slot_b_primary_enable_n_o, slot_b_secondary_enable_n_o,
      aux_peripheral_select_n_o};
   assign st_vec = {oe_n_o, iord_n_o};
   // Design under test and the card on its far side
   hbc_ctrl i_hbc_ctrl (.mclk_i, .reset_n_i, .cfg_we_i, .cfg_addr_i,
      .cfg_wdata_i, .cfg_rdata_o, .host_cfg_i, .acc_i, .irq_req_i, .host_cs_i,
      .host_read_or_dir_i, .host_write_or_strobe_i, .slot_a_wait_n_i,
      .slot_b_wait_n_i, .host_wait_or_ack_o, .host_wait_or_ack_oe_o,
      .host_irq_o, .host_irq_oe_o, .slot_a_primary_enable_n_o,
      .slot_a_secondary_enable_n_o, .slot_b_primary_enable_n_o,
      .slot_b_secondary_enable_n_o, .aux_peripheral_select_n_o, .reg_n_o,
      .oe_n_o, .we_n_o, .iord_n_o, .iowr_n_o, .addr_buffer_latch_en_o,
      .addr_buffer_oe_n_o, .data_buffer_dir_o, .data_buffer_oe_n_o);
   hbc_card_model i_hbc_card_model (.mclk_i(mclk_i),
      .strobe_n_i(oe_n_o & iord_n_o), .wait_b_i(wait_b),
      .wait_len_i(wait_len), .slot_a_wait_n_o(slot_a_wait_n_i),
      .slot_b_wait_n_o(slot_b_wait_n_i));
   // -------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // -------------------------------------------------------------
   always #5 mclk_i = ~mclk_i;
   // A hung handshake loop would otherwise spin forever
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         stop_test;
      end
   end
   task automatic stop_test;
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Inputs move 1 ns after the edge, outputs are read there too
   task automatic tick;
      @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_reset;
      reset_n_i = 1'b0;
      repeat (5) tick;
      reset_n_i = 1'b1;
   endtask
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      cfg_we_i = 1'b1;
      cfg_addr_i = a;
      cfg_wdata_i = d;
      tick;
      cfg_we_i = 1'b0;
      tick;
   endtask
   task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
      cfg_addr_i = a;
      repeat (2) tick;
      d = cfg_rdata_o;
   endtask
   // Host pins in the locked configuration's polarity and pin function
   task automatic pins(input logic on);
      host_cs_i = on ~^ lk.cs_pol;
      host_read_or_dir_i = on ~^ lk.rd_pol;
      host_write_or_strobe_i = (on & lk.write_pin_func_sel) ~^ lk.wr_pol;
   endtask
   // Unmapped write and a zero to the lock are both ignored
   task automatic lock;
      cfg_wr(8'h1e, 8'h01);
      cfg_wr(8'h1f, 8'h00);
      cfg_rd(8'h1f, v);
      chk(v, 8'h00);
      cfg_wr(8'h1f, 8'h01);
      host_cfg_i = hbc_cfg_t'(~lk);
      cfg_rd(8'h1e, v);
      chk(v, 8'h00);
      cfg_rd(8'h1f, v);
      chk(v, 8'h01);
      chk(8'(addr_buffer_oe_n_o), 8'h00);
   endtask
   // One host read, timed phase by phase against the tables
   task automatic rd(input hbc_dest_t d, input hbc_space_t s,
         input hbc_tim_t t, input logic [3:0] w, input logic wb);
      int tm;
      logic [7:0] c;
      logic [4:0] ee;
      tm = (s == SP_IO || s == SP_EC || s == SP_EXT) ? 6 :
         (s == SP_ATTR) ? ((t == TM_600) ? 0 : 1) :
         (t == TM_300 || t == TM_IO) ? 2 : int'(t);
      ee = (s == SP_EXT) ? 5'h1e : (d == DST_B) ?
         ((s == SP_EC) ? 5'h1d : 5'h1b) : ((s == SP_EC) ? 5'h17 : 5'h0f);
      acc_i = '{dest: d, space: s, tim: t};
      wait_len = w;
      wait_b = wb;
      pins(1'b1);
      c = 8'h00;
      while (en_vec === 5'h1f) begin
         tick;
         c++;
      end
      // Start detection plus decode must land inside the allowed window
      chk(8'(c > 8'h02 && c < 8'h07), 8'h01);
      chk(8'({en_vec, reg_n_o}),
         8'({ee, s == SP_COMMON || s == SP_EXT}));
      c = 8'h00;
      while (st_vec === 2'b11) begin
         tick;
         c++;
      end
      chk(c, t3e[tm]);
      chk(8'({st_vec, data_buffer_dir_o, host_wait_or_ack_oe_o,
         host_wait_or_ack_o, we_n_o, iowr_n_o}),
         8'({(s > SP_COMMON) ? 2'b10 : 2'b01, 5'h1b}));
      c = 8'h00;
      while (host_wait_or_ack_o !== 1'b1) begin
         tick;
         c++;
      end
      chk(c, t4e[tm] + (((d == DST_B) === wb) ? 8'(w) : 8'h00));
      chk(8'(addr_buffer_latch_en_o), 8'h00);
      // Open drain wait lets go of the pin once the length expires
      chk(8'(host_wait_or_ack_oe_o), 8'(!lk.wa_od || lk.ack_mode));
      chk(cfg_rdata_o, 8'h03);
      pins(1'b0);
      c = 8'h00;
      while (st_vec !== 2'b11) begin
         tick;
         c++;
      end
      chk(8'(c >= t5e[tm]), 8'h01);
      chk(8'(data_buffer_oe_n_o), 8'h01);
      tick;
      chk(8'({en_vec, reg_n_o, addr_buffer_latch_en_o}), 8'h7f);
      c = 8'h01;
      while (data_buffer_oe_n_o !== 1'b0) begin
         tick;
         c++;
      end
      chk(c, t10e[tm] + 8'h01);
      chk(8'(data_buffer_dir_o), 8'h00);
      repeat (3) tick;
   endtask
   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      host_cfg_i = P1;
      lk = P1;
      do_reset;
      irq_req_i = 1'b1;
      pins(1'b1);
      repeat (8) tick;
      chk({1'b0, en_vec, st_vec}, 8'h7f);
      chk(8'({host_wait_or_ack_oe_o, host_irq_oe_o, data_buffer_oe_n_o}),
         8'h01);
      pins(1'b0);
      lock;
      chk(8'({host_irq_oe_o, host_irq_o}), 8'h03);
      irq_req_i = 1'b0;
      tick;
      chk(8'({host_irq_oe_o, host_irq_o}), 8'h02);
      rd(DST_A, SP_ATTR, TM_600, 4'h0, 1'b0);
      rd(DST_A, SP_ATTR, TM_250, 4'h0, 1'b0);
      rd(DST_B, SP_COMMON, TM_300, 4'h0, 1'b0);
      rd(DST_A, SP_COMMON, TM_250, 4'h0, 1'b0);
      rd(DST_B, SP_COMMON, TM_200, 4'h0, 1'b0);
      rd(DST_A, SP_COMMON, TM_150, 4'h0, 1'b0);
      rd(DST_B, SP_COMMON, TM_100, 4'h0, 1'b0);
      rd(DST_A, SP_IO, TM_100, 4'h0, 1'b0);
      rd(DST_B, SP_EC, TM_600, 4'h0, 1'b0);
      rd(DST_AUX, SP_EXT, TM_600, 4'h0, 1'b0);
      rd(DST_B, SP_COMMON, TM_600, 4'h4, 1'b1);
      rd(DST_A, SP_COMMON, TM_600, 4'h4, 1'b1);
      host_cfg_i = P2;
      lk = P2;
      pins(1'b0);
      do_reset;
      lock;
      irq_req_i = 1'b1;
      tick;
      chk(8'({host_irq_oe_o, host_irq_o}), 8'h02);
      irq_req_i = 1'b0;
      tick;
      chk(8'(host_irq_oe_o), 8'h00);
      rd(DST_A, SP_IO, TM_IO, 4'h0, 1'b0);
      rd(DST_B, SP_COMMON, TM_200, 4'h3, 1'b1);
      rd(DST_A, SP_EC, TM_IO, 4'h0, 1'b0);
      stop_test;
   end
endmodule
`default_nettype wire
